// ---- cfr_pkg.sv ----
// Constants, types and helpers for the core status flags block.
// Assumes a single pclk domain; APB register offsets are byte addresses.
package cfr_pkg;

  localparam int CFR_DW = 8;
  localparam int CFR_AW = 8;
  localparam int CFR_IRQ_W = 4;

  // Flag bit positions
  localparam int CFR_BIT_C = 0;
  localparam int CFR_BIT_DC = 1;
  localparam int CFR_BIT_Z = 2;
  localparam int CFR_BIT_PD = 3;
  localparam int CFR_BIT_TO = 4;

  localparam logic [CFR_DW-1:0] CFR_FLAGS_RESET = 8'h18;

  // Affect masks, laid out as {z, dc, c}
  localparam logic [2:0] CFR_AFF_NONE = 3'h0;
  localparam logic [2:0] CFR_AFF_C = 3'h1;
  localparam logic [2:0] CFR_AFF_Z = 3'h4;
  localparam logic [2:0] CFR_AFF_ALL = 3'h7;

  // APB register byte offsets
  localparam logic [CFR_AW-1:0] CFR_OFF_FLAGS = 8'h00;
  localparam logic [CFR_AW-1:0] CFR_OFF_IRQ_STATUS = 8'h04;
  localparam logic [CFR_AW-1:0] CFR_OFF_IRQ_ENABLE = 8'h08;
  localparam logic [CFR_AW-1:0] CFR_OFF_IRQ_CLEAR = 8'h0C;
  localparam logic [CFR_AW-1:0] CFR_OFF_RESULT = 8'h10;

  // Interrupt status bit positions
  localparam int CFR_IRQ_TIMEOUT = 0;
  localparam int CFR_IRQ_SLEEP = 1;
  localparam int CFR_IRQ_WDCLR = 2;
  localparam int CFR_IRQ_BLOCKED = 3;

  typedef enum logic [3:0] {
    CFR_OP_NOP,
    CFR_OP_ADD_REG,
    CFR_OP_ADD_LIT,
    CFR_OP_SUB_REG,
    CFR_OP_SUB_LIT,
    CFR_OP_AND,
    CFR_OP_IOR,
    CFR_OP_XOR,
    CFR_OP_CLR,
    CFR_OP_MOV,
    CFR_OP_RRF,
    CFR_OP_RLF
  } cfr_op_t;

  // One executed instruction; sub ops compute opb - opa
  typedef struct packed {
    logic valid;
    cfr_op_t op;
    logic [CFR_DW-1:0] opa;
    logic [CFR_DW-1:0] opb;
    logic dest_status;
  } cfr_instr_t;

  typedef struct packed {
    logic [CFR_DW-1:0] result;
    logic z;
    logic dc;
    logic c;
    logic [2:0] affect;
  } cfr_alu_t;

  typedef struct packed {
    logic wdt_clear;
    logic sleep;
    logic wdt_timeout;
  } cfr_event_t;

  // Returns {carry, nibble carry, sum}
  function automatic logic [CFR_DW+1:0] cfr_add(input logic [CFR_DW-1:0] a, input logic [CFR_DW-1:0] b,
                                                input logic cin);
    logic [4:0] lo;
    logic [CFR_DW:0] full;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    return {full[CFR_DW], lo[4], full[CFR_DW-1:0]};
  endfunction : cfr_add

endpackage : cfr_pkg

// ---- cfr_alu.sv ----
// Result and flag computation for one instruction.
// Purely combinational; the caller registers the outputs.
`timescale 1ns/1ps
module cfr_alu (
  // Instruction in
  input cfr_pkg::cfr_instr_t instr,
  input wire logic carry_in,
  // Result out
  output cfr_pkg::cfr_alu_t res
);
  import cfr_pkg::*;

  logic [CFR_DW+1:0] add_w;
  logic [CFR_DW+1:0] sub_w;

  assign add_w = cfr_add(instr.opb, instr.opa, 1'b0);
  // Borrow shows as carry low, straight from the complement sum
  assign sub_w = cfr_add(instr.opb, ~instr.opa, 1'b1);

  always_comb begin
    res = '0;
    res.affect = CFR_AFF_NONE;
    case (instr.op)
      CFR_OP_ADD_REG, CFR_OP_ADD_LIT: begin
        {res.c, res.dc, res.result} = add_w;
        res.affect = CFR_AFF_ALL;
      end
      CFR_OP_SUB_REG, CFR_OP_SUB_LIT: begin
        {res.c, res.dc, res.result} = sub_w;
        res.affect = CFR_AFF_ALL;
      end
      CFR_OP_AND: begin
        res.result = instr.opa & instr.opb;
        res.affect = CFR_AFF_Z;
      end
      CFR_OP_IOR: begin
        res.result = instr.opa | instr.opb;
        res.affect = CFR_AFF_Z;
      end
      CFR_OP_XOR: begin
        res.result = instr.opa ^ instr.opb;
        res.affect = CFR_AFF_Z;
      end
      CFR_OP_CLR: begin
        res.result = '0;
        res.affect = CFR_AFF_Z;
      end
      CFR_OP_MOV: begin
        res.result = instr.opb;
      end
      CFR_OP_RRF: begin
        res.result = {carry_in, instr.opb[CFR_DW-1:1]};
        res.c = instr.opb[0];
        res.affect = CFR_AFF_C;
      end
      CFR_OP_RLF: begin
        res.result = {instr.opb[CFR_DW-2:0], carry_in};
        res.c = instr.opb[CFR_DW-1];
        res.affect = CFR_AFF_C;
      end
      default: begin
        res.result = '0;
      end
    endcase
    res.z = (res.result == '0);
  end

endmodule : cfr_alu

// ---- cfr_status_flags.sv ----
// Core status flags register with APB access and event interrupt.
// Assumes instr and events are synchronous to pclk, one cycle per instruction.
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
module cfr_status_flags (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cfr_pkg::CFR_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core datapath
  input cfr_pkg::cfr_instr_t instr,
  input cfr_pkg::cfr_event_t events,
  output logic [cfr_pkg::CFR_DW-1:0] flags_q,
  output logic [cfr_pkg::CFR_DW-1:0] result_q,
  output logic result_valid_q,
  // Interrupt
  output logic irq_q
);
  import cfr_pkg::*;

  cfr_alu_t alu_res;
  logic [CFR_DW-1:0] flags_d;
  logic [CFR_IRQ_W-1:0] irq_status_q;
  logic [CFR_IRQ_W-1:0] irq_status_d;
  logic [CFR_IRQ_W-1:0] irq_enable_q;
  logic [CFR_IRQ_W-1:0] irq_enable_d;
  logic [CFR_IRQ_W-1:0] irq_set;
  logic [CFR_IRQ_W-1:0] irq_clr;
  logic [31:0] prdata_d;
  logic [31:0] rd_data;
  logic pready_d;
  logic pslverr_d;

  cfr_alu u_alu (
    .instr(instr),
    .carry_in(flags_q[CFR_BIT_C]),
    .res(alu_res)
  );

  // APB decode
  wire apb_access = psel & penable;
  wire apb_first = apb_access & ~pready;
  wire apb_done = apb_access & pready;
  wire sel_flags = (paddr == CFR_OFF_FLAGS);
  wire sel_status = (paddr == CFR_OFF_IRQ_STATUS);
  wire sel_enable = (paddr == CFR_OFF_IRQ_ENABLE);
  wire sel_clear = (paddr == CFR_OFF_IRQ_CLEAR);
  wire sel_result = (paddr == CFR_OFF_RESULT);
  wire mapped = sel_flags | sel_status | sel_enable | sel_clear | sel_result;
  wire apb_wr = apb_done & pwrite;

  assign rd_data = sel_flags ? {24'h0, flags_q} :
                   sel_status ? {28'h0, irq_status_q} :
                   sel_enable ? {28'h0, irq_enable_q} :
                   sel_result ? {24'h0, result_q} : 32'h0;

  // One wait state: answer is registered
  assign pready_d = apb_first;
  assign pslverr_d = apb_first & ~mapped;
  assign prdata_d = apb_first ? rd_data : prdata;

  // Flag merge. Core instruction beats a same-cycle APB write to the flags.
  wire exec = instr.valid;
  wire to_status = exec & instr.dest_status;
  wire flags_wr = apb_wr & sel_flags & ~exec;
  wire [2:0] alu_flags = {alu_res.z, alu_res.dc, alu_res.c};
  wire [2:0] aff_mask = exec ? alu_res.affect : CFR_AFF_NONE;
  wire [2:0] data_low = to_status ? alu_res.result[2:0] :
                        flags_wr ? pwdata[2:0] : flags_q[2:0];
  // Computed flags override data on affected bits
  wire [2:0] low_d = (alu_flags & aff_mask) | (data_low & ~aff_mask);
  // Only core events move the reset-cause flags
  wire to_d = events.wdt_timeout ? 1'b0 :
              (events.wdt_clear | events.sleep) ? 1'b1 : flags_q[CFR_BIT_TO];
  wire pd_d = events.sleep ? 1'b0 :
              events.wdt_clear ? 1'b1 : flags_q[CFR_BIT_PD];

  always_comb begin
    flags_d = '0;
    flags_d[CFR_BIT_C] = low_d[0];
    flags_d[CFR_BIT_DC] = low_d[1];
    flags_d[CFR_BIT_Z] = low_d[2];
    flags_d[CFR_BIT_PD] = pd_d;
    flags_d[CFR_BIT_TO] = to_d;
  end

  // Interrupt events; set wins over clear
  always_comb begin
    irq_set = '0;
    irq_set[CFR_IRQ_TIMEOUT] = events.wdt_timeout;
    irq_set[CFR_IRQ_SLEEP] = events.sleep;
    irq_set[CFR_IRQ_WDCLR] = events.wdt_clear;
    irq_set[CFR_IRQ_BLOCKED] = to_status & (alu_res.affect != CFR_AFF_NONE);
  end

  assign irq_clr = (apb_wr & sel_clear) ? pwdata[CFR_IRQ_W-1:0] : '0;
  assign irq_status_d = (irq_status_q & ~irq_clr) | irq_set;
  assign irq_enable_d = (apb_wr & sel_enable) ? pwdata[CFR_IRQ_W-1:0] : irq_enable_q;

  // Power-up sets both reset-cause flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= CFR_FLAGS_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q <= '0;
      result_valid_q <= 1'b0;
    end else begin
      result_q <= exec ? alu_res.result : result_q;
      result_valid_q <= exec;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= '0;
      irq_enable_q <= '0;
      irq_q <= 1'b0;
    end else begin
      irq_status_q <= irq_status_d;
      irq_enable_q <= irq_enable_d;
      irq_q <= |(irq_status_d & irq_enable_d);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= prdata_d;
      pready <= pready_d;
      pslverr <= pslverr_d;
    end
  end

endmodule : cfr_status_flags

// ---- cfr_status_flags_checker.sv ----
// Assertions on the flag outputs of the status flags block.
// Bound to cfr_status_flags; sees its ports only.
`timescale 1ns/1ps
module cfr_status_flags_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Core side
  input cfr_pkg::cfr_instr_t instr,
  input cfr_pkg::cfr_event_t events,
  input wire logic [7:0] flags_q,
  input wire logic [7:0] result_q
);
  import cfr_pkg::*;
  logic [8:0] add_w;
  logic [4:0] addl_w;
  logic [1:0] add_cd;
  logic rot_out;
  logic quiet;
  assign add_w = {1'b0, instr.opa} + {1'b0, instr.opb};
  assign addl_w = {1'b0, instr.opa[3:0]} + {1'b0, instr.opb[3:0]};
  // Laid out as flags_q[1:0]: nibble carry above carry
  assign add_cd = {addl_w[4], add_w[8]};
  assign rot_out = (instr.op == CFR_OP_RRF) ? instr.opb[0] : instr.opb[7];
  assign quiet = (events == 3'h0);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_top_zero: assert property (flags_q[7:5] == 3'h0) else $error("top bits set");
  a_add_carry: assert property (instr.valid && instr.op inside {CFR_OP_ADD_REG, CFR_OP_ADD_LIT} |=>
    flags_q[1:0] == $past(add_cd)) else $error("add carry wrong");
  a_logic_zero: assert property (instr.valid && instr.op inside {CFR_OP_AND, CFR_OP_IOR, CFR_OP_XOR} |=>
    flags_q[2] == (result_q == 8'h00)) else $error("zero flag wrong");
  a_rot_carry: assert property (instr.valid && instr.op inside {CFR_OP_RRF, CFR_OP_RLF} |=>
    flags_q[0] == $past(rot_out)) else $error("rotate carry wrong");
  a_timeout_clr: assert property (events.wdt_timeout |=> !flags_q[4]) else $error("expiry not cleared");
  a_sleep_set: assert property (events.sleep && !events.wdt_timeout |=>
    flags_q[4:3] == 2'b10) else $error("sleep flags wrong");
  a_keep_reset: assert property (instr.valid && instr.dest_status && quiet |=>
    $stable(flags_q[4:3])) else $error("reset cause bits written");
  a_quiet_keep: assert property (instr.valid && instr.op inside {CFR_OP_NOP, CFR_OP_MOV} && !instr.dest_status
    && quiet |=> $stable(flags_q)) else $error("flags moved");
endmodule : cfr_status_flags_checker

// ---- cfr_core_model.sv ----
// Core model issuing instructions and event pulses to the flags block.
// Tasks are called from one bench process; pclk is the core clock.
`timescale 1ns/1ps
module cfr_core_model (
  // Clock
  input wire logic pclk,
  // Core outputs
  output cfr_pkg::cfr_instr_t instr,
  output cfr_pkg::cfr_event_t events
);
  import cfr_pkg::*;
  initial begin
    instr = '0;
    events = '0;
  end
  task automatic exec(input cfr_op_t op, input logic [7:0] a, input logic [7:0] b, input logic d);
    @(posedge pclk);
    instr <= '{1'b1, op, a, b, d};
    @(posedge pclk);
    // Stale operands inverted so nothing leans on them
    instr <= '{1'b0, op, ~a, ~b, ~d};
    #1;
  endtask : exec
  task automatic pulse(input cfr_event_t ev);
    @(posedge pclk);
    events <= ev;
    @(posedge pclk);
    events <= '0;
    #1;
  endtask : pulse
endmodule : cfr_core_model

// ---- cfr_status_flags_test.sv ----
// Self-checking bench for the status flags block.
// Drives APB and the core model; waits on pready, bounded.
`timescale 1ns/1ps
module cfr_status_flags_test;
  import cfr_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_q, e, result_valid_q;
  logic [7:0] paddr, flags_q, result_q;
  logic [31:0] pwdata, prdata, q;
  cfr_instr_t instr;
  cfr_event_t events;
  int errors, samples_checked;
  cfr_status_flags u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .instr, .events, .flags_q, .result_q, .result_valid_q, .irq_q);
  cfr_core_model u_core (.pclk, .instr, .events);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk
  task automatic fl(input logic [31:0] x);
    chk({24'h0, flags_q}, x);
  endtask : fl
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) errors++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask : rd
  task automatic end_sim;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    errors = 0;
    samples_checked = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(CFR_OFF_FLAGS, 32'h18);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, CFR_OFF_IRQ_ENABLE, 32'h1);
    u_core.exec(CFR_OP_ADD_REG, 8'h01, 8'hFF, 1'b0);
    fl(32'h1F);
    chk({31'h0, result_valid_q}, 32'h1);
    u_core.exec(CFR_OP_SUB_LIT, 8'h03, 8'h05, 1'b0);
    fl(32'h1B);
    u_core.exec(CFR_OP_SUB_REG, 8'h05, 8'h03, 1'b0);
    fl(32'h18);
    u_core.exec(CFR_OP_RLF, 8'h00, 8'h80, 1'b0);
    fl(32'h19);
    u_core.exec(CFR_OP_RRF, 8'h00, 8'h02, 1'b0);
    chk({24'h0, result_q}, 32'h81);
    u_core.exec(CFR_OP_AND, 8'h0F, 8'hF0, 1'b0);
    fl(32'h1C);
    u_core.exec(CFR_OP_MOV, 8'h55, 8'h55, 1'b0);
    fl(32'h1C);
    rd(CFR_OFF_RESULT, 32'h55);
    apb(1'b1, CFR_OFF_FLAGS, 32'hE7);
    rd(CFR_OFF_FLAGS, 32'h1F);
    chk({31'h0, result_valid_q}, 32'h0);
    u_core.exec(CFR_OP_CLR, 8'h00, 8'h00, 1'b1);
    fl(32'h1C);
    u_core.exec(CFR_OP_XOR, 8'h0F, 8'hF0, 1'b1);
    fl(32'h1B);
    u_core.pulse(3'b010);
    fl(32'h13);
    chk({31'h0, irq_q}, 32'h0);
    u_core.pulse(3'b001);
    fl(32'h03);
    u_core.pulse(3'b100);
    fl(32'h1B);
    rd(CFR_OFF_IRQ_STATUS, 32'hF);
    chk({31'h0, irq_q}, 32'h1);
    apb(1'b1, CFR_OFF_IRQ_CLEAR, 32'hF);
    rd(CFR_OFF_IRQ_STATUS, 32'h0);
    chk({31'h0, irq_q}, 32'h0);
    // Mid-run reset after sleep: power-up values again
    u_core.pulse(3'b010);
    fl(32'h13);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    fl(32'h18);
    chk({24'h0, result_q}, 32'h0);
    u_core.exec(CFR_OP_ADD_LIT, 8'h08, 8'h08, 1'b0);
    fl(32'h1A);
    end_sim;
  end
  initial begin
    #20us;
    errors++;
    end_sim;
  end
endmodule : cfr_status_flags_test
bind cfr_status_flags cfr_status_flags_checker u_chk (.pclk, .presetn, .instr, .events, .flags_q, .result_q);
